// ---- core/timer16_consts.svh ----
// Register offsets, field positions, reset values and timing figures of the 16-bit timer.
// Included by the package and by every design file that needs the numbers.
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

`define CLOCK_PERIOD_NS 20
// APB byte addresses.
`define OFF_COUNT 12'h000
`define OFF_FIRST_CC 12'h004
`define OFF_SECOND_CC 12'h008
`define OFF_MODE_CTRL 12'h00c
`define OFF_CC_SELECT 12'h010
`define OFF_OUT_CTRL 12'h014
`define OFF_PRESCALE 12'h018
// Mode control fields.
`define MODE_WRAP_BIT 0
`define MODE_TOGGLE_BIT 1
`define MODE_FIELD_LO 2
`define MODE_FIELD_HI 3
// Capture/compare select fields.
`define SEL_FIRST_CAPTURE_BIT 0
`define SEL_FIRST_SOURCE_BIT 1
`define SEL_SECOND_CAPTURE_BIT 2
// Output control fields.
`define OUT_ENABLE_BIT 0
`define OUT_SINGLE_EN_BIT 5
`define OUT_SINGLE_TRIG_BIT 6
// Prescaler fields.
`define PRE_DIV_LO 0
`define PRE_DIV_HI 1
`define PRE_EDGE1_LO 4
`define PRE_EDGE1_HI 5
`define PRE_EDGE2_LO 6
`define PRE_EDGE2_HI 7
// Reset values.
`define RESET_COUNT 16'h0000
`define RESET_CC 16'h0000
`define RESET_CTRL 8'h00
// Edge select encodings.
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

`endif

// ---- core/timer16_pkg.sv ----
// Types shared by the 16-bit timer files.
// Assumes timer16_consts.svh is on the include path.
`default_nettype none
`include "timer16_consts.svh"

package timer16_pkg;
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_FREE,
    MODE_EDGE_CLEAR,
    MODE_PERIODIC
  } op_mode_e;

  typedef struct packed {
    logic second;
    logic first;
  } match_events_s;
endpackage : timer16_pkg

`default_nettype wire

// ---- core/edge_sense.sv ----
// Synchroniser and valid-edge detector for one trigger pin.
// Assumes the pin is asynchronous to clock; the select comes from a register on clock.
`default_nettype none
`include "timer16_consts.svh"

module edge_sense (
  input wire logic clock,
  input wire logic reset,
  input wire logic pinIn,
  input wire logic [1:0] edgeSelect,
  output logic edgePulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic rise;
  logic fall;

  // The first stage is read only by the second stage to keep metastability contained.
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;

  always_comb begin
    unique case (edgeSelect)
      `EDGE_NONE: edgePulse = 1'b0;
      `EDGE_RISE: edgePulse = rise;
      `EDGE_FALL: edgePulse = fall;
      `EDGE_BOTH: edgePulse = rise | fall;
    endcase
  end
endmodule : edge_sense

`default_nettype wire

// ---- core/count_prescaler.sv ----
// Count clock enable generator: one pulse every 1, 2, 4 or 8 clocks.
// Assumes run and divSelect come from registers on the same clock.
`default_nettype none

module count_prescaler (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic [1:0] divSelect,
  output logic tick
);
  logic [2:0] div_reg;
  logic [2:0] mask;

  assign mask = 3'(({2'h0, 1'b1} << divSelect) - 3'h1);
  assign tick = run & ((div_reg & mask) == mask);

  // Stopping the timer restarts the divider so the first count is a full period.
  always_ff @(posedge clock) begin
    if (reset || !run) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= 3'(div_reg + 3'h1);
    end
  end
endmodule : count_prescaler

`default_nettype wire

// ---- core/timer16_freerun_ppg_oneshot.sv ----
// 16-bit up-counting timer with two capture/compare registers, free-running,
// periodic pulse and one-shot output, reached over an APB slave.
// Assumes trigger pins are asynchronous and APB runs on clock.
`default_nettype none
`include "timer16_consts.svh"

module timer16_freerun_ppg_oneshot
  import timer16_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic firstTriggerInput,
  input wire logic secondCaptureInput,
  output logic timerOutputPin,
  output match_events_s matchEvents
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] firstCc_reg;
  logic [15:0] secondCc_reg;
  logic [1:0] opMode_reg;
  logic captureToggle_reg;
  logic wrapFlag_reg;
  logic [2:0] ccSelect_reg;
  logic outEnable_reg;
  logic singleEnable_reg;
  logic [7:0] prescale_reg;
  logic armed_reg;
  logic level_reg;
  logic level_next;
  logic [31:0] readData_reg;
  logic error_reg;
  match_events_s events_reg;

  op_mode_e mode;
  logic running;
  logic tick;
  logic firstEdge;
  logic secondEdge;
  logic setupPhase;
  logic writeAccess;
  logic swTrigger;
  logic oneShotMode;
  logic oneShotTrigger;
  logic restart;
  logic firstIsCapture;
  logic secondIsCapture;
  logic firstMatch;
  logic secondMatch;
  logic firstCapture;
  logic secondCapture;
  logic periodicClear;
  logic wrapEvent;
  logic mapped;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] offset);
    hit = (addr == offset);
  endfunction : hit

  assign mode = op_mode_e'(opMode_reg);
  assign running = (mode != MODE_STOP);

  count_prescaler prescaler (
    .clock(clock),
    .reset(reset),
    .run(running),
    .divSelect(prescale_reg[`PRE_DIV_HI:`PRE_DIV_LO]),
    .tick(tick)
  );

  edge_sense firstSense (
    .clock(clock),
    .reset(reset),
    .pinIn(firstTriggerInput),
    .edgeSelect(prescale_reg[`PRE_EDGE1_HI:`PRE_EDGE1_LO]),
    .edgePulse(firstEdge)
  );

  edge_sense secondSense (
    .clock(clock),
    .reset(reset),
    .pinIn(secondCaptureInput),
    .edgeSelect(prescale_reg[`PRE_EDGE2_HI:`PRE_EDGE2_LO]),
    .edgePulse(secondEdge)
  );

  // The slave never inserts wait states; read data is latched in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = error_reg;
  assign prdata = readData_reg;
  assign setupPhase = psel & ~penable;
  assign writeAccess = psel & penable & pwrite;
  assign swTrigger = writeAccess & hit(paddr, `OFF_OUT_CTRL) & pwdata[`OUT_SINGLE_TRIG_BIT];

  assign mapped = hit(paddr, `OFF_COUNT) | hit(paddr, `OFF_FIRST_CC) |
                  hit(paddr, `OFF_SECOND_CC) | hit(paddr, `OFF_MODE_CTRL) |
                  hit(paddr, `OFF_CC_SELECT) | hit(paddr, `OFF_OUT_CTRL) |
                  hit(paddr, `OFF_PRESCALE);

  assign firstIsCapture = ccSelect_reg[`SEL_FIRST_CAPTURE_BIT];
  assign secondIsCapture = ccSelect_reg[`SEL_SECOND_CAPTURE_BIT];

  // One-shot works only in the two non-periodic running modes.
  assign oneShotMode = singleEnable_reg & ((mode == MODE_FREE) || (mode == MODE_EDGE_CLEAR));
  // A retrigger during a pulse restarts it; software must avoid that.
  assign oneShotTrigger = oneShotMode & (swTrigger | firstEdge);
  assign restart = oneShotTrigger | ((mode == MODE_EDGE_CLEAR) & firstEdge);

  // Matches are sampled on the count clock, never between counts.
  assign firstMatch = running & tick & ~firstIsCapture & (count_reg == firstCc_reg);
  assign secondMatch = running & tick & ~secondIsCapture & (count_reg == secondCc_reg);

  // Capture source for the first register: 0 selects the capture input, 1 the trigger.
  assign firstCapture = running & firstIsCapture &
                        (ccSelect_reg[`SEL_FIRST_SOURCE_BIT] ? firstEdge : secondEdge);
  assign secondCapture = running & secondIsCapture & firstEdge;

  assign periodicClear = (mode == MODE_PERIODIC) & firstMatch;
  assign wrapEvent = running & tick & ~periodicClear & ~restart & (count_reg == 16'hffff);

  always_comb begin
    count_next = count_reg;
    if (!running) begin
      count_next = `RESET_COUNT;
    end else if (restart || periodicClear) begin
      count_next = 16'h0000;
    end else if (tick) begin
      count_next = 16'(count_reg + 16'h0001);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg <= `RESET_COUNT;
    end else begin
      count_reg <= count_next;
    end
  end

  // Hardware captures take priority over a software write in the same cycle.
  always_ff @(posedge clock) begin
    if (reset) begin
      firstCc_reg <= `RESET_CC;
    end else if (firstCapture) begin
      firstCc_reg <= count_reg;
    end else if (writeAccess && hit(paddr, `OFF_FIRST_CC)) begin
      firstCc_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      secondCc_reg <= `RESET_CC;
    end else if (secondCapture) begin
      secondCc_reg <= count_reg;
    end else if (writeAccess && hit(paddr, `OFF_SECOND_CC)) begin
      secondCc_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      opMode_reg <= 2'h0;
      captureToggle_reg <= 1'b0;
    end else if (writeAccess && hit(paddr, `OFF_MODE_CTRL)) begin
      opMode_reg <= pwdata[`MODE_FIELD_HI:`MODE_FIELD_LO];
      captureToggle_reg <= pwdata[`MODE_TOGGLE_BIT];
    end
  end

  // A wrap in the same cycle as a software clear keeps the flag set.
  always_ff @(posedge clock) begin
    if (reset) begin
      wrapFlag_reg <= 1'b0;
    end else if (wrapEvent) begin
      wrapFlag_reg <= 1'b1;
    end else if (writeAccess && hit(paddr, `OFF_MODE_CTRL) && !pwdata[`MODE_WRAP_BIT]) begin
      wrapFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ccSelect_reg <= 3'h0;
      outEnable_reg <= 1'b0;
      singleEnable_reg <= 1'b0;
      prescale_reg <= `RESET_CTRL;
    end else begin
      if (writeAccess && hit(paddr, `OFF_CC_SELECT)) begin
        ccSelect_reg <= pwdata[2:0];
      end
      if (writeAccess && hit(paddr, `OFF_OUT_CTRL)) begin
        outEnable_reg <= pwdata[`OUT_ENABLE_BIT];
        singleEnable_reg <= pwdata[`OUT_SINGLE_EN_BIT];
      end
      if (writeAccess && hit(paddr, `OFF_PRESCALE)) begin
        prescale_reg <= pwdata[7:0];
      end
    end
  end

  // The one-shot is armed by a trigger and disarmed by the closing match.
  always_ff @(posedge clock) begin
    if (reset || !oneShotMode) begin
      armed_reg <= 1'b0;
    end else if (oneShotTrigger) begin
      armed_reg <= 1'b1;
    end else if (firstMatch) begin
      armed_reg <= 1'b0;
    end
  end

  always_comb begin
    level_next = level_reg;
    unique case (mode)
      MODE_STOP: begin
        level_next = 1'b0;
      end
      MODE_PERIODIC: begin
        // Active while the count is at or below the second register: second+1 counts.
        level_next = (count_reg <= secondCc_reg);
      end
      MODE_FREE, MODE_EDGE_CLEAR: begin
        if (oneShotMode) begin
          if (oneShotTrigger) begin
            level_next = 1'b0;
          end else if (armed_reg && firstMatch) begin
            level_next = 1'b0;
          end else if (armed_reg && secondMatch) begin
            level_next = 1'b1;
          end
        end else if (firstIsCapture && secondIsCapture) begin
          if (captureToggle_reg && firstEdge) begin
            level_next = ~level_reg;
          end
        end else if (firstMatch ^ secondMatch) begin
          level_next = ~level_reg;
        end
      end
    endcase
    if (!outEnable_reg) begin
      level_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
    end
  end

  assign timerOutputPin = level_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      events_reg <= '0;
    end else begin
      events_reg.first <= firstMatch | firstCapture;
      events_reg.second <= secondMatch | secondCapture;
    end
  end

  assign matchEvents = events_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      readData_reg <= 32'h00000000;
      error_reg <= 1'b0;
    end else if (setupPhase) begin
      error_reg <= ~mapped;
      readData_reg <= 32'h00000000;
      if (!pwrite) begin
        if (hit(paddr, `OFF_COUNT)) begin
          readData_reg <= {16'h0000, count_reg};
        end
        if (hit(paddr, `OFF_FIRST_CC)) begin
          readData_reg <= {16'h0000, firstCc_reg};
        end
        if (hit(paddr, `OFF_SECOND_CC)) begin
          readData_reg <= {16'h0000, secondCc_reg};
        end
        if (hit(paddr, `OFF_MODE_CTRL)) begin
          readData_reg <= {28'h0000000, opMode_reg, captureToggle_reg, wrapFlag_reg};
        end
        if (hit(paddr, `OFF_CC_SELECT)) begin
          readData_reg <= {29'h0, ccSelect_reg};
        end
        if (hit(paddr, `OFF_OUT_CTRL)) begin
          readData_reg <= {26'h0, singleEnable_reg, 4'h0, outEnable_reg};
        end
        if (hit(paddr, `OFF_PRESCALE)) begin
          readData_reg <= {24'h000000, prescale_reg};
        end
      end
    end
  end
endmodule : timer16_freerun_ppg_oneshot

`default_nettype wire

// ---- test/timer16_chk.sv ----
// Checker for the 16-bit timer, bound to its top module.
// Assumes the count clock equals the system clock while periods and widths are judged.
`default_nettype none
module timer16_chk
  import timer16_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic firstTriggerInput,
  input wire logic secondCaptureInput,
  input wire logic timerOutputPin,
  input wire match_events_s matchEvents
);
  // Control registers are shadowed from bus writes, since only the ports are visible.
  logic [3:0] mode;
  logic [2:0] sel;
  logic [5:0] outc;
  logic [15:0] firstCc;
  logic [15:0] secondCc;
  logic [15:0] highRun;
  logic [16:0] gap;
  logic gapOk;
  logic wasSel;
  wire logic wr = psel && penable && pwrite;
  wire logic quiet = !psel && !wasSel;
  wire logic free = mode[3:2] == 2'b01;
  wire logic ppg = mode[3:2] == 2'b11;
  wire logic shot = (mode[3] != mode[2]) && outc[5] && outc[0];
  always_ff @(posedge clock) begin
    if (reset) begin
      mode <= 4'h0;
      sel <= 3'h0;
      outc <= 6'h00;
      firstCc <= 16'h0000;
      secondCc <= 16'h0000;
    end else if (wr) begin
      case (paddr)
        12'h004: firstCc <= pwdata[15:0];
        12'h008: secondCc <= pwdata[15:0];
        12'h00c: mode <= pwdata[3:0];
        12'h010: sel <= pwdata[2:0];
        12'h014: outc <= pwdata[5:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    wasSel <= psel;
    highRun <= timerOutputPin ? highRun + 16'h0001 : 16'h0000;
    gap <= matchEvents.first ? 17'h1 : 17'(gap + 17'h1);
    gapOk <= !reset && !wr && (gapOk || matchEvents.first);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_access;
    psel && penable;
  endsequence
  a_access_ready: assert property (s_access |-> pready)
    else $error("access phase without ready");
  a_first_pulse: assert property (matchEvents.first |=> !matchEvents.first)
    else $error("first match event longer than one cycle");
  a_second_pulse: assert property (matchEvents.second |=> !matchEvents.second)
    else $error("second match event longer than one cycle");
  a_free_toggle: assert property (free && sel == 3'h0 && outc[0] && !outc[5] && quiet
    |-> $changed(timerOutputPin) == (matchEvents.first ^ matchEvents.second))
    else $error("output toggle does not follow compare matches");
  a_dual_still: assert property (free && sel[0] && sel[2] && !mode[1] && quiet
    |-> $stable(timerOutputPin))
    else $error("output moved in dual capture without toggle enable");
  a_ppg_period: assert property (ppg && matchEvents.first && gapOk
    |-> gap == 17'({1'b0, firstCc} + 17'h1))
    else $error("periodic match spacing wrong");
  a_ppg_width: assert property (ppg && outc[0] && quiet && $fell(timerOutputPin)
    |-> highRun == secondCc + 16'h0001)
    else $error("periodic high width wrong");
  a_shot_width: assert property (shot && quiet && $fell(timerOutputPin)
    |-> highRun == firstCc - secondCc)
    else $error("single pulse width wrong");
  a_shot_start: assert property (shot && quiet && $rose(timerOutputPin)
    |-> matchEvents.second)
    else $error("single pulse began without second match");
endmodule : timer16_chk

bind timer16_freerun_ppg_oneshot timer16_chk chk (.clock(clock), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .firstTriggerInput(firstTriggerInput),
  .secondCaptureInput(secondCaptureInput), .timerOutputPin(timerOutputPin),
  .matchEvents(matchEvents));
`default_nettype wire

// ---- test/pin_partner.sv ----
// Model of the pins around the timer: two edge sources and a watcher on the output.
// Assumes the bench calls its task from the timer clock domain.
`default_nettype none
module pin_partner (
  input wire logic clock,
  input wire logic timerOutputPin,
  output logic firstTriggerInput,
  output logic secondCaptureInput
);
  timeunit 1ns;
  timeprecision 1ps;
  int toggles = 0;
  int highs = 0;
  logic lastLevel = 1'b0;
  // Both lines rest low between requested pulses so no stray edge fires a shot.
  initial begin
    firstTriggerInput = 1'b0;
    secondCaptureInput = 1'b0;
  end
  always @(posedge clock) begin
    toggles <= toggles + (timerOutputPin !== lastLevel);
    highs <= highs + (timerOutputPin === 1'b1);
    lastLevel <= timerOutputPin;
  end
  task automatic pulse(input bit trig, input int hold);
    @(posedge clock);
    if (trig) firstTriggerInput <= 1'b1;
    else secondCaptureInput <= 1'b1;
    repeat (hold) @(posedge clock);
    firstTriggerInput <= 1'b0;
    secondCaptureInput <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : pulse
endmodule : pin_partner
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the 16-bit timer over APB.
// Assumes the checker is bound and the pin model sits on the trigger pins.
`default_nettype none
module tb_top
  import timer16_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trig;
  logic capIn;
  logic pin;
  match_events_s ev;
  logic [31:0] rdata;
  logic lastErr;
  int fails = 0;
  int samplesChecked = 0;
  int evFirst = 0;
  int evSecond = 0;
  timer16_freerun_ppg_oneshot dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .firstTriggerInput(trig),
    .secondCaptureInput(capIn), .timerOutputPin(pin), .matchEvents(ev));
  pin_partner pins (.clock(clock), .timerOutputPin(pin), .firstTriggerInput(trig),
    .secondCaptureInput(capIn));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    evFirst <= evFirst + (ev.first === 1'b1);
    evSecond <= evSecond + (ev.second === 1'b1);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic t_regs;
    rd(12'h004);
    check(rdata, 32'h0);
    wr(12'h004, 32'h0000abcd);
    rd(12'h004);
    check(rdata, 32'h0000abcd);
    rd(12'h01c);
    check({31'h0, lastErr}, 32'h1);
    wr(12'h018, 32'h00000050);
  endtask : t_regs
  task automatic t_count;
    logic [15:0] c0;
    wr(12'h00c, 32'h4);
    rd(12'h000);
    c0 = rdata[15:0];
    rd(12'h000);
    check(rdata - c0, 32'h3);
    c0 = rdata[15:0];
    repeat (65600) @(posedge clock);
    rd(12'h000);
    check(rdata, {16'h0, c0 + 16'h0043});
    rd(12'h00c);
    check(rdata[0], 1'b1);
    wr(12'h00c, 32'h4);
    rd(12'h00c);
    check(rdata[0], 1'b0);
    // A 32-clock span between the two samples holds exactly four divide-by-8 ticks.
    wr(12'h018, 32'h00000053);
    rd(12'h000);
    c0 = rdata[15:0];
    repeat (29) @(posedge clock);
    rd(12'h000);
    check(rdata - c0, 32'h4);
    wr(12'h018, 32'h00000050);
  endtask : t_count
  task automatic t_free;
    int t0;
    int e1;
    int e2;
    wr(12'h00c, 32'h0);
    wr(12'h004, 32'h40);
    wr(12'h008, 32'h60);
    wr(12'h010, 32'h0);
    wr(12'h014, 32'h1);
    t0 = pins.toggles;
    e1 = evFirst;
    e2 = evSecond;
    wr(12'h00c, 32'h4);
    repeat (112) @(posedge clock);
    rd(12'h000);
    check(32'(rdata > 32'h60), 32'h1);
    check(pins.toggles - t0, 32'h2);
    check(evFirst - e1, 32'h1);
    check(evSecond - e2, 32'h1);
  endtask : t_free
  task automatic t_capture;
    logic [31:0] c0;
    int t0;
    int e2;
    wr(12'h00c, 32'h0);
    wr(12'h008, 32'h0);
    wr(12'h010, 32'h5);
    wr(12'h00c, 32'h4);
    t0 = pins.toggles;
    pins.pulse(1'b0, 4);
    rd(12'h008);
    check(rdata, 32'h0);
    rd(12'h004);
    check(32'(rdata < 32'h20), 32'h1);
    rd(12'h000);
    c0 = rdata;
    e2 = evSecond;
    pins.pulse(1'b1, 2);
    rd(12'h008);
    check(32'(rdata > c0 && rdata < c0 + 32'h20), 32'h1);
    check(evSecond - e2, 32'h1);
    check(pins.toggles - t0, 32'h0);
    wr(12'h00c, 32'h6);
    t0 = pins.toggles;
    pins.pulse(1'b1, 4);
    check(pins.toggles - t0, 32'h1);
  endtask : t_capture
  task automatic t_source;
    wr(12'h00c, 32'h0);
    wr(12'h004, 32'h0);
    wr(12'h010, 32'h3);
    wr(12'h00c, 32'h4);
    pins.pulse(1'b1, 20);
    rd(12'h004);
    check(32'(rdata != 32'h0), 32'h1);
    wr(12'h004, 32'h0);
    pins.pulse(1'b0, 4);
    rd(12'h004);
    check(rdata, 32'h0);
  endtask : t_source
  task automatic t_ppg;
    int h0;
    int e1;
    wr(12'h00c, 32'h0);
    wr(12'h010, 32'h0);
    // Second below first keeps the duty meaningful.
    wr(12'h004, 32'h9);
    wr(12'h008, 32'h3);
    wr(12'h00c, 32'hc);
    repeat (20) @(posedge clock);
    h0 = pins.highs;
    e1 = evFirst;
    repeat (50) @(posedge clock);
    check(pins.highs - h0, 32'd20);
    check(evFirst - e1, 32'd5);
  endtask : t_ppg
  task automatic t_shot;
    int h0;
    int t0;
    wr(12'h00c, 32'h0);
    wr(12'h004, 32'h10);
    wr(12'h008, 32'h8);
    wr(12'h014, 32'h21);
    wr(12'h00c, 32'h4);
    for (int k = 0; k < 3; k++) begin
      h0 = pins.highs;
      t0 = pins.toggles;
      if (k == 1) begin
        pins.pulse(1'b1, 4);
      end else begin
        if (k == 2) wr(12'h00c, 32'h8);
        wr(12'h014, 32'h61);
      end
      // Retriggering only after the pulse has ended.
      repeat (40) @(posedge clock);
      check(pins.highs - h0, 32'd8);
      check(pins.toggles - t0, 32'd2);
    end
  endtask : t_shot
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    t_regs;
    t_count;
    t_free;
    t_capture;
    t_source;
    t_ppg;
    t_shot;
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
